// ==== src/ilpc_consts.svh ====
// Behaviour
// [RL1] Global enable one accepts maskable sources; zero disables all but source 0.
// [RL2] With global enable zero, source 0 interrupts but never wakes from low power.
// [RL3] Source 0 request is latched; latch clears when its service routine begins.
// [RL4] Source 1: level select one gives level, zero gives falling edge detection.
// [RL5] Source 2 always edge detected; polarity bit one rising, zero falling.
// [RL6] Sources 3 and 4 are level sensitive with no storage.
// [RL7] An edge sets a latch held until its service routine starts.
// [RL8] Multiple edges before service leave only one pending request.
// [RL9] Level requester must hold line low when sampled after an instruction.
// [RL10] Requests tested after each instruction; acceptance replaces next instruction.
// [RL11] Entry: switch flags, push PC, inhibit maskables, clear latch, load vector.
// [RL12] Three carry/zero flag sets: normal, interrupt, non-maskable, auto selected.
// [RL13] Return restores previous flag set and pops saved PC.
// [RL14] Option register write-only, resets zero; bit 7 and bits 3..0 unused.
// [RL15] Routing: converter 4, timer/oscillator 3, port pins 2, serial 1, supervisor 0.
// [RL16] WAIT halts instructions only; clock, peripherals and state keep running.
// [RL17] Leaving WAIT by interrupt adds no stabilisation delay.
// [RL18] STOP only while watchdog disabled; oscillator halts until interrupt or reset.
// [RL19] Leaving STOP by interrupt inserts oscillator stabilisation delay.
// [RL20] Reset during low power runs normal reset, not interrupt resume.
// [RL21] Fixed priority source 1 highest; source 0 pre-empts; maskables never nest.
// [RL22] With watchdog active, STOP behaves as WAIT.
// [RL23] WAIT or STOP ignored when an enabled request is already pending.
// [RL24] STOP exit delay length is a parameter in oscillator cycles.
`ifndef ILPC_CONSTS_SVH
`define ILPC_CONSTS_SVH
`define ILPC_ADDR_OPTION 8'hC8
`define ILPC_ADDR_STATUS 8'hCC
`define ILPC_ADDR_CORE 8'hD0
`define ILPC_OPT_RESET 8'h00
`define ILPC_BIT_LES 6
`define ILPC_BIT_ESB 5
`define ILPC_BIT_GEN 4
`define ILPC_VEC_SRC0 12'hFFC
`define ILPC_VEC_SRC1 12'hFF6
`define ILPC_VEC_SRC2 12'hFF4
`define ILPC_VEC_SRC3 12'hFF2
`define ILPC_VEC_SRC4 12'hFF0
`define ILPC_STOP_DELAY 16
`endif

// ==== src/ilpc_ctrl.sv ====
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ilpc_consts.svh"
module ilpc_ctrl #(
   parameter int STOP_DELAY = `ILPC_STOP_DELAY
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ilpc_pkg::ilpc_src_s src,
   input wire ilpc_pkg::ilpc_core_s core,
   input wire logic [11:0] pc_in,
   input wire logic watchdog_active,
   output logic irq_take,
   output logic [11:0] vector_reg,
   output logic [11:0] pc_reg,
   output logic push_reg,
   output logic pop_reg,
   output logic cf_reg,
   output logic zf_reg,
   output logic core_halt_reg,
   output logic osc_run_reg
);
   // ********************************************************************
   // Input synchronisation
   // ********************************************************************
   logic [5:0] s1, s2, s3, srcf;
   logic osc_on;
   assign osc_on = osc_run_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Reset to the idle level of each pin, so no false edge follows.
         s1 <= 6'h07;
         s2 <= 6'h07;
         s3 <= 6'h07;
         srcf <= 6'h07;
      end else if (clk_en) begin
         s1 <= {src.adc_eoc, src.timer_ovf, src.lfo_event, src.port_irq_n,
                src.spi_eot_n, src.pss_irq_n};
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < 6; i++) begin
            if (s2[i] == s3[i]) begin
               srcf[i] <= s2[i];
            end
         end
      end
   end
   // Sources 3 and 4 are active high from peripherals; made active low here.
   logic src0_n, src1_n, src2_n, src3_n, src4_n;
   assign src0_n = srcf[0];
   assign src1_n = srcf[1];
   assign src2_n = srcf[2];
   assign src3_n = ~(srcf[3] | srcf[4]); // see [RL15]
   assign src4_n = ~srcf[5]; // see [RL15]

   // ********************************************************************
   // Option register and APB
   // ********************************************************************
   logic [7:0] irq_option_reg;
   logic global_irq_enable, src1_level_select, src2_edge_polarity;
   logic wr_acc, rd_acc;
   assign wr_acc = psel & penable & pwrite & clk_en;
   assign rd_acc = psel & penable & ~pwrite & clk_en;
   assign global_irq_enable = irq_option_reg[`ILPC_BIT_GEN];
   assign src1_level_select = irq_option_reg[`ILPC_BIT_LES];
   assign src2_edge_polarity = irq_option_reg[`ILPC_BIT_ESB];

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `ILPC_ADDR_OPTION) || (a == `ILPC_ADDR_STATUS) ||
                (a == `ILPC_ADDR_CORE);
   endfunction : addr_ok

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_option_reg <= `ILPC_OPT_RESET; // see [RL14]
      end else if (wr_acc && paddr == `ILPC_ADDR_OPTION) begin
         irq_option_reg <= pwdata[7:0] & 8'h70; // see [RL14]
      end
   end

   logic [1:0] fset;
   logic [1:0] pmode;
   logic [5:0] pend;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok(paddr);
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            // The option register reads as zero since it is write-only.
            if (paddr == `ILPC_ADDR_STATUS) begin
               prdata <= {26'h0, pend};
            end else if (paddr == `ILPC_ADDR_CORE) begin
               prdata <= {28'h0, fset, pmode};
            end
         end
      end
   end

   // ********************************************************************
   // Request detection
   // ********************************************************************
   logic src0_d, src1_d, src2_d;
   logic lat0, lat1, lat2;
   logic in_irq, in_nmi;
   logic ack0, ack1, ack2;
   logic rise2, fall2, fall1, fall0;
   assign fall0 = src0_d & ~src0_n;
   assign fall1 = src1_d & ~src1_n;
   assign rise2 = ~src2_d & src2_n;
   assign fall2 = src2_d & ~src2_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src0_d <= 1'b1;
         src1_d <= 1'b1;
         src2_d <= 1'b1;
      end else if (clk_en) begin
         src0_d <= src0_n;
         src1_d <= src1_n;
         src2_d <= src2_n;
      end
   end

   // Set beats the clear so an edge arriving at service start is not lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat0 <= 1'b0;
         lat1 <= 1'b0;
         lat2 <= 1'b0;
      end else if (clk_en) begin
         if (fall0) begin
            lat0 <= 1'b1; // see [RL3]
         end else if (ack0) begin
            lat0 <= 1'b0; // see [RL3]
         end
         if (!src1_level_select && fall1) begin
            lat1 <= 1'b1; // see [RL4] see [RL7] see [RL8]
         end else if (ack1 || src1_level_select) begin
            lat1 <= 1'b0; // see [RL7]
         end
         if (src2_edge_polarity ? rise2 : fall2) begin
            lat2 <= 1'b1; // see [RL5] see [RL7] see [RL8]
         end else if (ack2) begin
            lat2 <= 1'b0; // see [RL7]
         end
      end
   end

   logic [4:0] req;
   assign req[0] = lat0;
   assign req[1] = src1_level_select ? ~src1_n : lat1; // see [RL4] see [RL9]
   assign req[2] = lat2;
   assign req[3] = ~src3_n; // see [RL6]
   assign req[4] = ~src4_n; // see [RL6]
   assign pend = {req, global_irq_enable};

   logic mask_ok;
   assign mask_ok = global_irq_enable & ~in_irq & ~in_nmi; // see [RL1] see [RL21]
   logic [4:1] mreq;
   assign mreq = req[4:1] & {4{mask_ok}};
   logic nmi_ok;
   assign nmi_ok = req[0] & ~in_nmi; // see [RL21]
   logic any_enabled;
   assign any_enabled = nmi_ok | (|mreq);
   logic wake_ok;
   assign wake_ok = global_irq_enable & (req[0] | (|(req[4:1] &
                    {4{~in_irq & ~in_nmi}}))); // see [RL2]

   function automatic logic [2:0] pick(input logic n, input logic [4:1] m);
      if (n) begin
         pick = 3'd0;
      end else if (m[1]) begin
         pick = 3'd1; // see [RL21]
      end else if (m[2]) begin
         pick = 3'd2;
      end else if (m[3]) begin
         pick = 3'd3;
      end else if (m[4]) begin
         pick = 3'd4;
      end else begin
         pick = 3'd7;
      end
   endfunction : pick

   function automatic logic [11:0] vec_of(input logic [2:0] s);
      case (s)
         3'd0: vec_of = `ILPC_VEC_SRC0;
         3'd1: vec_of = `ILPC_VEC_SRC1;
         3'd2: vec_of = `ILPC_VEC_SRC2;
         3'd3: vec_of = `ILPC_VEC_SRC3;
         default: vec_of = `ILPC_VEC_SRC4;
      endcase
   endfunction : vec_of

   logic [2:0] sel;
   logic take;
   assign sel = pick(nmi_ok, mreq);
   assign take = core.instr_end && pmode == ilpc_pkg::ILPC_PM_RUN &&
                 any_enabled; // see [RL10]
   assign ack0 = take && sel == 3'd0;
   assign ack1 = take && sel == 3'd1;
   assign ack2 = take && sel == 3'd2;

   // ********************************************************************
   // Entry and return sequence, flag sets
   // ********************************************************************
   logic [1:0] prev_fset;
   logic nmi_from_irq;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fset <= ilpc_pkg::ILPC_FS_NORMAL;
         in_irq <= 1'b0;
         in_nmi <= 1'b0;
         nmi_from_irq <= 1'b0;
         irq_take <= 1'b0;
         vector_reg <= 12'h000;
         pc_reg <= 12'h000;
         push_reg <= 1'b0;
         pop_reg <= 1'b0;
      end else if (clk_en) begin
         irq_take <= take; // see [RL10]
         push_reg <= take; // see [RL11]
         pop_reg <= 1'b0;
         if (take) begin
            pc_reg <= pc_in; // see [RL11]
            vector_reg <= vec_of(sel); // see [RL11]
            if (sel == 3'd0) begin
               fset <= ilpc_pkg::ILPC_FS_NMI; // see [RL11] see [RL12]
               in_nmi <= 1'b1;
               nmi_from_irq <= in_irq;
            end else begin
               fset <= ilpc_pkg::ILPC_FS_IRQ; // see [RL12]
               in_irq <= 1'b1; // see [RL11]
            end
         end else if (core.return_from_irq_exec && core.instr_end) begin
            pop_reg <= 1'b1; // see [RL13]
            if (in_nmi) begin
               in_nmi <= 1'b0;
               fset <= nmi_from_irq ? ilpc_pkg::ILPC_FS_IRQ :
                       ilpc_pkg::ILPC_FS_NORMAL; // see [RL13]
            end else begin
               in_irq <= 1'b0;
               fset <= ilpc_pkg::ILPC_FS_NORMAL; // see [RL13]
            end
         end
      end
   end
   assign prev_fset = fset;

   logic [2:0] cfs, zfs;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfs <= 3'b000;
         zfs <= 3'b000;
      end else if (clk_en && core.flag_wr) begin
         cfs[fset] <= core.cf_in; // see [RL12]
         zfs[fset] <= core.zf_in;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cf_reg <= 1'b0;
         zf_reg <= 1'b0;
      end else if (clk_en) begin
         cf_reg <= cfs[prev_fset]; // see [RL12]
         zf_reg <= zfs[prev_fset];
      end
   end

   // ********************************************************************
   // WAIT and STOP
   // ********************************************************************
   logic [15:0] stab_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pmode <= ilpc_pkg::ILPC_PM_RUN; // see [RL20]
         stab_cnt <= 16'h0;
         core_halt_reg <= 1'b0;
         osc_run_reg <= 1'b1;
      end else if (clk_en) begin
         case (pmode)
            ilpc_pkg::ILPC_PM_RUN: begin
               if (core.instr_end && !any_enabled) begin // see [RL23]
                  if (core.stop_exec && !watchdog_active) begin
                     pmode <= ilpc_pkg::ILPC_PM_STOP; // see [RL18]
                     core_halt_reg <= 1'b1;
                     osc_run_reg <= 1'b0; // see [RL18]
                  end else if (core.wait_exec || core.stop_exec) begin
                     pmode <= ilpc_pkg::ILPC_PM_WAIT; // see [RL16] see [RL22]
                     core_halt_reg <= 1'b1;
                  end
               end
            end
            ilpc_pkg::ILPC_PM_WAIT: begin
               if (wake_ok) begin
                  pmode <= ilpc_pkg::ILPC_PM_RUN; // see [RL17]
                  core_halt_reg <= 1'b0;
               end
            end
            ilpc_pkg::ILPC_PM_STOP: begin
               if (wake_ok) begin
                  pmode <= ilpc_pkg::ILPC_PM_STAB; // see [RL19]
                  osc_run_reg <= 1'b1;
                  stab_cnt <= 16'(STOP_DELAY); // see [RL24]
               end
            end
            ilpc_pkg::ILPC_PM_STAB: begin
               if (stab_cnt <= 16'h1) begin
                  pmode <= ilpc_pkg::ILPC_PM_RUN; // see [RL19]
                  core_halt_reg <= 1'b0;
               end else begin
                  stab_cnt <= stab_cnt - 16'h1;
               end
            end
            default: pmode <= ilpc_pkg::ILPC_PM_RUN;
         endcase
      end
   end
endmodule : ilpc_ctrl

// ==== src/ilpc_pkg.sv ====
package ilpc_pkg;
   typedef enum logic [1:0] {
      ILPC_FS_NORMAL = 2'b00,
      ILPC_FS_IRQ = 2'b01,
      ILPC_FS_NMI = 2'b10
   } ilpc_flagset_e;
   typedef enum logic [1:0] {
      ILPC_PM_RUN = 2'b00,
      ILPC_PM_WAIT = 2'b01,
      ILPC_PM_STOP = 2'b10,
      ILPC_PM_STAB = 2'b11
   } ilpc_pmode_e;
   typedef struct packed {
      logic instr_end;
      logic wait_exec;
      logic stop_exec;
      logic return_from_irq_exec;
      logic cf_in;
      logic zf_in;
      logic flag_wr;
   } ilpc_core_s;
   typedef struct packed {
      logic adc_eoc;
      logic timer_ovf;
      logic lfo_event;
      logic port_irq_n;
      logic spi_eot_n;
      logic pss_irq_n;
   } ilpc_src_s;
endpackage : ilpc_pkg

// ==== test/ilpc_core_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Core stand-in
// ****************************************
module ilpc_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic halt,
   input wire logic [3:0] gap,
   output ilpc_pkg::ilpc_core_s core,
   output logic [11:0] pc
);
   logic [3:0] cnt;
   ilpc_pkg::ilpc_core_s nxt = '0;
   // Matching on the qualifiers makes the wait immune to edge ordering.
   task automatic issue(input logic [6:0] c);
      nxt = c;
      @(posedge pclk iff core.instr_end && core[5:0] == c[5:0]);
      nxt = '0;
   endtask : issue
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         core <= '0;
         pc <= 12'h100;
      end else begin
         core <= '0;
         if (halt) begin
            cnt <= 4'h0;
         end else if (cnt >= gap) begin
            cnt <= 4'h0;
            core <= nxt | 7'h40;
            pc <= pc + 12'h001;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : ilpc_core_model

// ==== test/ilpc_ctrl_properties.sv ====
`timescale 1ns/1ps
// ****************************************
// Checker on the controller ports
// ****************************************
module ilpc_ctrl_properties #(
   parameter int STOP_DELAY = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire ilpc_pkg::ilpc_core_s core,
   input wire logic [11:0] pc_in,
   input wire logic watchdog_active,
   input wire logic irq_take,
   input wire logic [11:0] pc_reg,
   input wire logic push_reg,
   input wire logic pop_reg,
   input wire logic core_halt_reg,
   input wire logic osc_run_reg
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_opt_wo;
      psel && !penable && !pwrite && paddr == 8'hC8 |=>
         pready && prdata == 32'h0;
   endproperty
   a_opt_wo: assert property (p_opt_wo)
      else $error("option register read back nonzero");
   property p_take;
      irq_take |-> $past(core.instr_end);
   endproperty
   a_take: assert property (p_take)
      else $error("irq taken without instruction end");
   property p_push;
      irq_take |-> push_reg && pc_reg == $past(pc_in);
   endproperty
   a_push: assert property (p_push)
      else $error("entry did not push the program counter");
   property p_pop;
      pop_reg == $past(core.instr_end && core.return_from_irq_exec);
   endproperty
   a_pop: assert property (p_pop)
      else $error("pop not tied to return");
   property p_stop_wd;
      core.instr_end && core.stop_exec && watchdog_active |=> osc_run_reg;
   endproperty
   a_stop_wd: assert property (p_stop_wd)
      else $error("oscillator stopped with watchdog active");
   property p_osc_wd;
      !osc_run_reg |-> !watchdog_active;
   endproperty
   a_osc_wd: assert property (p_osc_wd)
      else $error("oscillator off while watchdog active");
   property p_osc_halt;
      !osc_run_reg |-> core_halt_reg;
   endproperty
   a_osc_halt: assert property (p_osc_halt)
      else $error("core running with oscillator off");
   property p_stab;
      $rose(osc_run_reg) |-> core_halt_reg ##1 core_halt_reg;
   endproperty
   a_stab: assert property (p_stab)
      else $error("no stabilisation hold after stop");
endmodule : ilpc_ctrl_properties

bind ilpc_ctrl ilpc_ctrl_properties #(.STOP_DELAY(STOP_DELAY)) u_props (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .core(core),
   .pc_in(pc_in),
   .watchdog_active(watchdog_active),
   .irq_take(irq_take),
   .pc_reg(pc_reg),
   .push_reg(push_reg),
   .pop_reg(pop_reg),
   .core_halt_reg(core_halt_reg),
   .osc_run_reg(osc_run_reg)
);

// ==== test/tb_interrupt_and_low_power_control.sv ====
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module tb_interrupt_and_low_power_control;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic wd = 1'b0;
   logic ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic err, pready, pslverr, irq_take, push_reg, pop_reg, cf_reg, zf_reg;
   logic core_halt_reg, osc_run_reg;
   logic [11:0] pc, vector_reg, pc_reg;
   logic [3:0] gap = 4'h3;
   ilpc_pkg::ilpc_src_s src = 6'h07;
   ilpc_pkg::ilpc_core_s core;
   int error_cnt = 0;
   int checks_done = 0;
   int n;
   localparam int SD = 2;
   always #12.5 pclk = ~pclk;
   ilpc_ctrl #(.STOP_DELAY(SD)) dut (.pclk, .presetn, .clk_en(ce),
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .src, .core, .pc_in(pc), .watchdog_active(wd), .irq_take, .vector_reg,
      .pc_reg, .push_reg, .pop_reg, .cf_reg, .zf_reg, .core_halt_reg,
      .osc_run_reg);
   ilpc_core_model m (.pclk, .presetn, .halt(core_halt_reg), .gap, .core,
      .pc);
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic flip(input logic [5:0] f);
      @(posedge pclk);
      src <= src ^ f;
   endtask : flip
   // The core keeps running, so any instruction end may take the request.
   task automatic take(input logic [11:0] e);
      logic [11:0] v;
      v = 12'h000;
      repeat (24) begin
         @(posedge pclk);
         if (irq_take === 1'b1 && v === 12'h000)
            v = vector_reg;
      end
      chk("vector", {20'h0, e}, {20'h0, v});
   endtask : take
   task automatic t_regs();
      bus(1'b0, 8'hCC, 32'h0);
      chk("enable at reset", 32'h0, {31'h0, rd[0]});
      bus(1'b1, 8'hC8, 32'h10);
      bus(1'b0, 8'hC8, 32'h0);
      chk("option read", 32'h0, rd);
      bus(1'b0, 8'hCC, 32'h0);
      chk("enable", 32'h1, {31'h0, rd[0]});
      bus(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      bus(1'b1, 8'hC8, 32'h0);
      // A flag write while the clock enable is low must not land.
      ce <= 1'b0;
      m.issue(7'h05);
      ce <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("frozen flags", 32'h0, {31'h0, cf_reg});
   endtask : t_regs
   task automatic t_gen_off();
      flip(6'h10);
      take(12'h000);
      flip(6'h01);
      take(12'hFFC);
      flip(6'h11);
      m.issue(7'h08);
      take(12'h000);
   endtask : t_gen_off
   task automatic t_edges();
      bus(1'b1, 8'hC8, 32'h10);
      m.issue(7'h05);
      flip(6'h06);
      take(12'hFF6);
      chk("irq flags", 32'h0, {31'h0, cf_reg});
      flip(6'h06);
      flip(6'h04);
      repeat (6) @(posedge pclk);
      flip(6'h04);
      m.issue(7'h08);
      repeat (3) @(posedge pclk);
      chk("normal flags", 32'h1, {31'h0, cf_reg});
      take(12'hFF4);
      m.issue(7'h08);
      take(12'h000);
   endtask : t_edges
   task automatic t_level();
      bus(1'b1, 8'hC8, 32'h50);
      gap <= 4'h1;
      flip(6'h02);
      take(12'hFF6);
      m.issue(7'h08);
      take(12'hFF6);
      flip(6'h32);
      // Let the released level pass the synchroniser before returning.
      repeat (6) @(posedge pclk);
      m.issue(7'h08);
      take(12'hFF2);
      flip(6'h30);
      repeat (6) @(posedge pclk);
      m.issue(7'h08);
      take(12'h000);
      gap <= 4'h3;
   endtask : t_level
   task automatic t_rise();
      bus(1'b1, 8'hC8, 32'h30);
      flip(6'h04);
      take(12'h000);
      flip(6'h04);
      take(12'hFF4);
      m.issue(7'h08);
   endtask : t_rise
   task automatic wake(input logic [6:0] op, input logic osc);
      m.issue(op);
      repeat (3) @(posedge pclk);
      chk("halt", 32'h1, {31'h0, core_halt_reg});
      chk("osc", {31'h0, osc}, {31'h0, osc_run_reg});
      flip(6'h20);
      n = 0;
      while (core_halt_reg === 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk("woken", 32'h1, {31'h0, n < 40});
      take(12'hFF0);
      flip(6'h20);
      repeat (6) @(posedge pclk);
      m.issue(7'h08);
   endtask : wake
   task automatic t_power();
      bus(1'b1, 8'hC8, 32'h10);
      wake(7'h20, 1'b1);
      chk("wait exit fast", 32'h1, {31'h0, n <= 6});
      wd <= 1'b1;
      wake(7'h10, 1'b1);
      wd <= 1'b0;
      wake(7'h10, 1'b0);
      chk("stop exit delay", 32'h1, {31'h0, n >= SD + 6});
   endtask : t_power
   task automatic t_gen_low_wake();
      bus(1'b1, 8'hC8, 32'h0);
      m.issue(7'h10);
      flip(6'h01);
      repeat (16) @(posedge pclk);
      chk("no wake", 32'h1, {31'h0, core_halt_reg});
      presetn <= 1'b0;
      src <= 6'h07;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("reset exit", 32'h1, {31'h0, osc_run_reg & ~core_halt_reg});
   endtask : t_gen_low_wake
   task automatic results();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_gen_off();
      t_edges();
      t_level();
      t_rise();
      t_power();
      t_gen_low_wake();
      results();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      results();
   end
endmodule : tb_interrupt_and_low_power_control
